// File: core/lsc_top.sv
/*
 Serial segment-command interpreter: link shift register, strobe crossing,
 command decode, display-on flag, latched rows and an APB register slave.
 Assumes the host holds the frame still from before the strobe rises until
 after it falls, far longer than the strobe synchroniser takes.
*/
`timescale 1ns/1ns
`default_nettype none
module lsc_top
    import lsc_pkg::*;
#(
    parameter int ROWS = LSC_ROWS,
    parameter int SEG_W = LSC_SEG_W
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic ser_clk_in,
    input wire logic ser_data_in,
    input wire logic ser_load_in,
    input wire lsc_apb_req_t apb_req_in,
    output lsc_apb_rsp_t apb_rsp_out,
    output logic [ROWS-1:0][SEG_W-1:0] seg_row_out
);

    typedef struct packed {
        logic [1:0] ld_sync;
        lsc_frame_t fr_s1;
        lsc_frame_t fr_s2;
        lsc_ld_st_t ld_st;
        logic disp_on;
        logic hold_blank;
        logic [LSC_CMD_W-1:0] last_cmd;
        logic [7:0] ign_cnt;
        lsc_apb_rsp_t rsp;
    } lsc_top_st_t;

    lsc_top_st_t st_r;
    lsc_top_st_t st_nxt;

    lsc_frame_t link_frame;
    logic [ROWS-1:0][SEG_W-1:0] row_q;
    logic exec_w;
    logic row_we;
    logic [1:0] row_sel;
    logic [3:0] op_w;
    logic apb_acc;
    logic apb_done;
    logic [LSC_ADDR_W-1:0] addr_w;
    logic [31:0] rdata_w;
    logic rerr_w;

    lsc_shift u_shift (
        .ser_clk_in(ser_clk_in),
        .ser_data_in(ser_data_in),
        .frame_out(link_frame)
    );

    // The stored frame is checked and executed only from the second stage
    assign op_w = st_r.fr_s2.cmd[LSC_CMD_W-1:LSC_CMD_W-4];
    assign exec_w = (st_r.ld_st == LSC_ST_WAIT) && st_r.ld_sync[1]; // R10
    assign row_we = exec_w && (op_w == LSC_OP_WRITE_ROW); // R2 R7
    assign row_sel = st_r.fr_s2.cmd[1:0]; // R3

    lsc_rows #(
        .ROWS(ROWS),
        .SEG_W(SEG_W)
    ) u_rows (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .we_in(row_we),
        .sel_in(row_sel),
        .data_in(st_r.fr_s2.seg), // R12
        .blank_in(!st_r.disp_on || st_r.hold_blank),
        .row_q_out(row_q),
        .seg_out(seg_row_out)
    );

    assign apb_acc = apb_req_in.psel && apb_req_in.penable;
    assign apb_done = apb_acc && st_r.rsp.pready;
    assign addr_w = apb_req_in.paddr;

    // Read decode; unmapped addresses answer with an error and zero data
    always_comb begin
        rdata_w = 32'h0000_0000;
        rerr_w = 1'b0;
        if (addr_w == LSC_CTRL_OFF) begin
            rdata_w[LSC_CTRL_HOLD_BIT] = st_r.hold_blank;
        end else if (addr_w == LSC_STATUS_OFF) begin
            rdata_w[LSC_STATUS_ON_BIT] = st_r.disp_on;
            rdata_w[LSC_STATUS_CMD_LSB +: LSC_CMD_W] = st_r.last_cmd;
            rdata_w[LSC_STATUS_IGN_LSB +: 8] = st_r.ign_cnt;
        end else if (addr_w[LSC_ADDR_W-1:4] == LSC_ROW_BASE_OFF[LSC_ADDR_W-1:4] &&
                     addr_w[1:0] == 2'b00) begin
            rdata_w = row_q[addr_w[3:2]];
        end else begin
            rerr_w = 1'b1;
        end
    end

    always_comb begin
        st_nxt = st_r;
        // The frame is stable around the strobe, so two plain stages suffice
        st_nxt.ld_sync = {st_r.ld_sync[0], ser_load_in};
        st_nxt.fr_s1 = link_frame;
        st_nxt.fr_s2 = st_r.fr_s1;

        case (st_r.ld_st)
            LSC_ST_WAIT: begin
                if (st_r.ld_sync[1]) begin
                    st_nxt.ld_st = LSC_ST_HELD;
                end
            end
            LSC_ST_HELD: begin
                if (!st_r.ld_sync[1]) begin
                    st_nxt.ld_st = LSC_ST_WAIT;
                end
            end
            default: begin
                st_nxt.ld_st = LSC_ST_WAIT;
            end
        endcase

        if (exec_w) begin
            st_nxt.last_cmd = st_r.fr_s2.cmd; // R10
            case (op_w)
                LSC_OP_WRITE_ROW: begin
                    st_nxt.disp_on = st_r.disp_on;
                end
                LSC_OP_BLANK: begin
                    st_nxt.disp_on = 1'b0; // R5 R8 R15
                end
                LSC_OP_UNBLANK: begin
                    st_nxt.disp_on = 1'b1; // R6 R8 R15
                end
                default: begin
                    // Ignored code: rows and display flag stay, only counted and recorded in last_cmd
                    st_nxt.ign_cnt = 8'(st_r.ign_cnt + 8'h01); // R7
                end
            endcase
        end

        if (apb_done) begin
            st_nxt.rsp.pready = 1'b0;
            st_nxt.rsp.pslverr = 1'b0;
            st_nxt.rsp.prdata = 32'h0000_0000;
            if (apb_req_in.pwrite && addr_w == LSC_CTRL_OFF) begin
                st_nxt.hold_blank = apb_req_in.pwdata[LSC_CTRL_HOLD_BIT];
            end
        end else if (apb_acc) begin
            // One wait state: the answer is registered so outputs come from flops
            st_nxt.rsp.pready = 1'b1;
            st_nxt.rsp.pslverr = rerr_w;
            st_nxt.rsp.prdata = apb_req_in.pwrite ? 32'h0000_0000 : rdata_w;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            st_r.ld_sync <= 2'b00;
            st_r.fr_s1 <= '0;
            st_r.fr_s2 <= '0;
            st_r.ld_st <= LSC_ST_WAIT;
            st_r.disp_on <= LSC_DISP_ON_RST; // R4
            st_r.hold_blank <= LSC_HOLD_RST;
            st_r.last_cmd <= '0;
            st_r.ign_cnt <= LSC_IGN_RST;
            st_r.rsp <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign apb_rsp_out = st_r.rsp;

    sequence s_exec_write;
        exec_w && op_w == LSC_OP_WRITE_ROW;
    endsequence

    sequence s_exec_blank;
        exec_w && op_w == LSC_OP_BLANK;
    endsequence

    sequence s_exec_unblank;
        exec_w && op_w == LSC_OP_UNBLANK;
    endsequence

    sequence s_exec_other;
        exec_w && op_w != LSC_OP_WRITE_ROW && op_w != LSC_OP_BLANK &&
        op_w != LSC_OP_UNBLANK;
    endsequence

    property p_row_write;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        s_exec_write |=> row_q[$past(row_sel)] == $past(st_r.fr_s2.seg);
    endproperty
    a_row_write: assert property (p_row_write) else $error("row not written"); // R2 R3

    property p_row_shown;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (s_exec_write ##1 (st_r.disp_on && !st_r.hold_blank && !row_we)) |=>
        seg_row_out[$past(row_sel, 2)] == $past(st_r.fr_s2.seg, 2);
    endproperty
    a_row_shown: assert property (p_row_shown) else $error("written row not shown"); // R12

    property p_reset_blank;
        @(posedge sys_clk_in)
        sys_rst_in |=> !st_r.disp_on && seg_row_out == '0;
    endproperty
    a_reset_blank: assert property (p_reset_blank) else $error("display on after reset"); // R4

    property p_blank;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        s_exec_blank |=> !st_r.disp_on ##1 seg_row_out == '0;
    endproperty
    a_blank: assert property (p_blank) else $error("segments not blanked"); // R5 R8

    property p_blank_keeps_rows;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (s_exec_blank or s_exec_unblank) |=> $stable(row_q);
    endproperty
    a_blank_keeps_rows: assert property (p_blank_keeps_rows) else $error("rows lost"); // R15

    property p_unblank;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (s_exec_unblank ##1 !st_r.hold_blank) |=> seg_row_out == $past(row_q);
    endproperty
    a_unblank: assert property (p_unblank) else $error("display not restored"); // R6

    property p_ignored;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        s_exec_other |=> $stable(row_q) && $stable(st_r.disp_on) &&
        st_r.ign_cnt == 8'($past(st_r.ign_cnt) + 8'h01);
    endproperty
    a_ignored: assert property (p_ignored) else $error("ignored code acted"); // R7

    property p_cmd_capture;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        $rose(st_r.ld_sync[1]) |-> exec_w ##1 st_r.last_cmd == $past(st_r.fr_s2.cmd);
    endproperty
    a_cmd_capture: assert property (p_cmd_capture) else $error("wrong command taken"); // R10

    property p_flag_cause;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        !$stable(st_r.disp_on) |-> $past(exec_w) && $past(st_r.ld_sync[1]);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag moved alone"); // R15

    property p_one_exec;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        exec_w |=> !exec_w;
    endproperty
    a_one_exec: assert property (p_one_exec) else $error("strobe executed twice"); // R2

    property p_apb_wait;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (apb_acc && !st_r.rsp.pready) |=> st_r.rsp.pready ##1 !st_r.rsp.pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");

endmodule
`default_nettype wire

// File: pkg/lsc_pkg.sv
/*
 Shared constants and carrier types for the serial segment-command front end.
 Assumes one system clock domain and one serial link clock made by the host.
*/
// What this block does
// [R1] Each rising serial clock edge shifts the serial data level into the frame register.
// [R2] While the latch strobe is high a data-write frame is copied into the latched display rows.
// [R3] A data-write command (upper bits 0010) picks the written common row from its two low bits.
// [R4] Power-on reset leaves the display blanked until the display-on command arrives.
// [R5] Upper command bits 1010 blank all segment outputs whatever the latched data.
// [R6] Upper command bits 1011 leave blanking and show the previously latched display again.
// [R7] Any other command code moves nothing into the rows; only the frame register changes. Here ign_cnt and last_cmd also change.
// [R8] Blank and unblank work when only the four upper command bits were shifted in.
// [R9] A host sending extra bits puts the padding first so the real frame arrives last.
// [R10] The command executed is the six command bits held just before the strobe rises.
// [R11] After an ignored command the host resends its data with a data-write command.
// [R12] A frame carries 32 segment on/off bits followed by the command field.
// [R13] The host holds reset active from power-up until the logic supply is good.
// [R14] Segment bits go first, then the low command bits, the top command bit last.
// [R15] One display-on flag, set by unblank, cleared by blank and reset, leaves rows unchanged.
package lsc_pkg;

    localparam int LSC_SEG_W = 32;
    localparam int LSC_CMD_W = 6;
    localparam int LSC_FRAME_W = LSC_SEG_W + LSC_CMD_W;
    localparam int LSC_ROWS = 4;
    localparam int LSC_ADDR_W = 12;

    // Upper four command bits
    localparam logic [3:0] LSC_OP_WRITE_ROW = 4'h2;
    localparam logic [3:0] LSC_OP_BLANK = 4'hA;
    localparam logic [3:0] LSC_OP_UNBLANK = 4'hB;

    // Register byte offsets
    localparam logic [LSC_ADDR_W-1:0] LSC_CTRL_OFF = 12'h000;
    localparam logic [LSC_ADDR_W-1:0] LSC_STATUS_OFF = 12'h004;
    localparam logic [LSC_ADDR_W-1:0] LSC_ROW_BASE_OFF = 12'h010;

    // Field positions
    localparam int LSC_CTRL_HOLD_BIT = 0;
    localparam int LSC_STATUS_ON_BIT = 0;
    localparam int LSC_STATUS_CMD_LSB = 8;
    localparam int LSC_STATUS_IGN_LSB = 16;

    // Reset values
    localparam logic LSC_DISP_ON_RST = 1'b0;
    localparam logic LSC_HOLD_RST = 1'b0;
    localparam logic [7:0] LSC_IGN_RST = 8'h00;

    // Frame as it sits in the shift register: last shifted bit is cmd[5]
    typedef struct packed {
        logic [LSC_CMD_W-1:0] cmd;
        logic [LSC_SEG_W-1:0] seg;
    } lsc_frame_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [LSC_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } lsc_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } lsc_apb_rsp_t;

    typedef enum logic [1:0] {
        LSC_ST_WAIT = 2'b01,
        LSC_ST_HELD = 2'b10
    } lsc_ld_st_t;

endpackage

// File: core/lsc_shift.sv
/*
 Serial frame shift register on the link clock.
 Assumes the host stops the serial clock while the latch strobe is high.
*/
`timescale 1ns/1ns
`default_nettype none
module lsc_shift
    import lsc_pkg::*;
(
    input wire logic ser_clk_in,
    input wire logic ser_data_in,
    output lsc_frame_t frame_out
);

    typedef struct packed {
        lsc_frame_t sr;
    } lsc_shift_st_t;

    lsc_shift_st_t st_r;
    lsc_shift_st_t st_nxt;

    // No reset: the link clock may be stopped, and the frame is data only
    always_comb begin
        st_nxt = st_r;
        st_nxt.sr = lsc_frame_t'({ser_data_in, st_r.sr[LSC_FRAME_W-1:1]}); // R1 R14
    end

    always_ff @(posedge ser_clk_in) begin
        st_r <= st_nxt;
    end

    assign frame_out = st_r.sr;

    property p_shift_in;
        @(posedge ser_clk_in)
        // Case equality: the unreset register is unknown until a whole frame has passed
        st_r.sr[LSC_FRAME_W-1] === $past(ser_data_in) &&
        st_r.sr[LSC_FRAME_W-2:0] === $past(st_r.sr[LSC_FRAME_W-1:1]);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("frame bit not shifted in"); // R1

endmodule
`default_nettype wire

// File: core/lsc_rows.sv
/*
 Latched display rows, one per common, with the blanked segment view registered.
 Assumes a single write port driven by the command decoder.
*/
`timescale 1ns/1ns
`default_nettype none
module lsc_rows
    import lsc_pkg::*;
#(
    parameter int ROWS = LSC_ROWS,
    parameter int SEG_W = LSC_SEG_W
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic we_in,
    input wire logic [$clog2(ROWS)-1:0] sel_in,
    input wire logic [SEG_W-1:0] data_in,
    input wire logic blank_in,
    output logic [ROWS-1:0][SEG_W-1:0] row_q_out,
    output logic [ROWS-1:0][SEG_W-1:0] seg_out
);

    typedef struct packed {
        logic [ROWS-1:0][SEG_W-1:0] rows;
        logic [ROWS-1:0][SEG_W-1:0] seg;
    } lsc_rows_st_t;

    lsc_rows_st_t st_r;
    lsc_rows_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < ROWS; i++) begin
            if (we_in && sel_in == i[$clog2(ROWS)-1:0]) begin
                st_nxt.rows[i] = data_in; // R2 R3
            end
            // Blanking gates the view only; stored rows survive it
            st_nxt.seg[i] = blank_in ? '0 : st_r.rows[i]; // R5 R6 R15
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign row_q_out = st_r.rows;
    assign seg_out = st_r.seg;

endmodule
`default_nettype wire

// File: testbench/lsc_host.sv
/*
 Host-side model of the three-wire serial link: serial clock, data and latch strobe.
 Assumes the bench calls send() between frames; the link clock runs only inside a frame.
*/
`timescale 1ns/1ns
`default_nettype none
module lsc_host (
    output logic ser_clk_out,
    output logic ser_data_out,
    output logic ser_load_out
);
    initial begin
        ser_clk_out = 1'b0;
        ser_data_out = 1'b0;
        ser_load_out = 1'b0;
    end

    // Bit 0 goes out first: segment bits, then command bits, top command bit last
    // Padding, if any, sits in the low bits so the real frame arrives last
    task automatic send(input logic [63:0] bits, input int n);
        #5;
        for (int i = 0; i < n; i++) begin
            ser_data_out = bits[i];
            #16 ser_clk_out = 1'b1;
            #16 ser_clk_out = 1'b0;
        end
        // Released line shows the inverse so a stale level cannot pass for data
        ser_data_out = ~ser_data_out;
        // Clock stays still well past 100 ns around a strobe of 200 ns
        #200 ser_load_out = 1'b1;
        #200 ser_load_out = 1'b0;
        #200;
    endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
/*
 Self-checking bench: APB master, serial host model, queued read checks.
 Assumes the APB slave answers with wait states and the link clock is unrelated.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import lsc_pkg::*;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    wire logic ser_clk, ser_data, ser_load;
    lsc_apb_req_t req = '0;
    lsc_apb_rsp_t rsp;
    logic [3:0][31:0] seg;
    logic [31:0] rows [4];
    logic [32:0] exp_q [$];
    logic [31:0] msk_q [$];
    logic on = 1'b0;
    logic hold = 1'b0;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int seed;
    int n;
    logic [31:0] d;

    always #2 sys_clk_in = ~sys_clk_in;

    lsc_host host (.ser_clk_out(ser_clk), .ser_data_out(ser_data), .ser_load_out(ser_load));

    lsc_top dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .ser_clk_in(ser_clk),
        .ser_data_in(ser_data), .ser_load_in(ser_load), .apb_req_in(req),
        .apb_rsp_out(rsp), .seg_row_out(seg));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        input logic [32:0] e, input logic [31:0] m);
        @(posedge sys_clk_in);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        if (!wr) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge sys_clk_in);
        req.penable <= 1'b1;
        do @(posedge sys_clk_in); while (rsp.pready !== 1'b1 && cyc < 60000);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic chk_seg();
        repeat (4) @(posedge sys_clk_in);
        for (int r = 0; r < 4; r++) begin
            chk("seg_row", seg[r], (on && !hold) ? rows[r] : 32'h0);
        end
    endtask

    task automatic wrow(input logic [1:0] r, input logic [31:0] v);
        host.send({LSC_OP_WRITE_ROW, r, v}, 38);
        rows[r] = v;
    endtask

    // Read results are compared in order as each completion shows up
    always @(posedge sys_clk_in) begin
        if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite
            && exp_q.size() > 0) begin
            chk("prdata", rsp.prdata & msk_q[0], exp_q[0][31:0]);
            chk("pslverr", {31'h0, rsp.pslverr}, {31'h0, exp_q[0][32]});
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end

    // Hang guard: the planned sequence needs about 27700 cycles
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            end_sim();
        end
    end

    initial begin
        seed = 32'h539C;
        for (int r = 0; r < 4; r++) rows[r] = 32'h0;
        repeat (20) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge sys_clk_in);
        chk_seg();
        apb(1'b0, LSC_STATUS_OFF, 32'h0, 33'h0, 32'h0000_0001);
        for (int r = 0; r < 4; r++) wrow(r[1:0], $random(seed));
        chk_seg();
        for (int r = 0; r < 4; r++) begin
            apb(1'b0, LSC_ROW_BASE_OFF + 12'(4 * r), 32'h0, {1'b0, rows[r]}, 32'hFFFF_FFFF);
        end
        host.send({60'h0, LSC_OP_UNBLANK}, 4);
        on = 1'b1;
        chk_seg();
        host.send({LSC_OP_BLANK, 2'h3, 32'hFFFF_FFFF}, 38);
        on = 1'b0;
        chk_seg();
        host.send({LSC_OP_UNBLANK, 2'h2, 32'h0000_0000}, 38);
        on = 1'b1;
        chk_seg();
        d = $random(seed);
        host.send({LSC_OP_WRITE_ROW, 2'h1, d, 5'h15}, 43);
        rows[1] = d;
        chk_seg();
        n = 0;
        for (int c = 0; c < 64; c++) begin
            if (!(c[5:2] inside {LSC_OP_WRITE_ROW, LSC_OP_BLANK, LSC_OP_UNBLANK})) begin
                host.send({c[5:0], 32'($random(seed))}, 38);
                n++;
            end
        end
        chk_seg();
        apb(1'b0, LSC_STATUS_OFF, 32'h0, {9'h0, 8'(n), 16'h0001}, 32'h00FF_0001);
        wrow(2'h0, $random(seed));
        chk_seg();
        apb(1'b1, LSC_CTRL_OFF, 32'h0000_0001, 33'h0, 32'h0);
        hold = 1'b1;
        chk_seg();
        apb(1'b0, LSC_CTRL_OFF, 32'h0, 33'h1, 32'h0000_0001);
        apb(1'b1, LSC_CTRL_OFF, 32'h0, 33'h0, 32'h0);
        hold = 1'b0;
        chk_seg();
        apb(1'b0, 12'h0FC, 32'h0, {1'b1, 32'h0}, 32'hFFFF_FFFF);
        apb(1'b0, LSC_ROW_BASE_OFF + 12'h002, 32'h0, {1'b1, 32'h0}, 32'hFFFF_FFFF);
        // Reset again in mid-run: display must go dark and rows clear
        @(posedge sys_clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        on = 1'b0;
        for (int r = 0; r < 4; r++) rows[r] = 32'h0;
        chk_seg();
        apb(1'b0, LSC_STATUS_OFF, 32'h0, 33'h0, 32'h00FF_0001);
        apb(1'b0, LSC_ROW_BASE_OFF, 32'h0, 33'h0, 32'hFFFF_FFFF);
        repeat (4) @(posedge sys_clk_in);
        end_sim();
    end
endmodule
`default_nettype wire
